// *** late_write_sram_pkg.sv ***
// constants and types for the late-write sram command controller
package late_write_sram_pkg;

  localparam int ADDR_W     = 4;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int BURST_W    = 2;
  localparam int HOLD_DEPTH = 2;
  localparam int WRITE_LAG  = 2;

  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [BURST_W-1:0] BURST_LAST  = 2'h3;

  typedef enum logic [1:0] {
    OP_BANK_DES,
    OP_CHIP_DES,
    OP_READ,
    OP_WRITE
  } op_t;

endpackage : late_write_sram_pkg

// *** hold_link_if.sv ***
// valid/ready carrier between the controller and its hold buffer
`timescale 1ns/10ps
interface hold_link_if #(parameter int W = 8);
  logic         inValid;
  logic         inReady;
  logic [W-1:0] inData;
  logic         outValid;
  logic         outReady;
  logic [W-1:0] outData;
  logic         full;

  modport fill (output inValid, inData, outReady,
                input  inReady, outValid, outData, full);
  modport store (input  inValid, inData, outReady,
                 output inReady, outValid, outData, full);
endinterface : hold_link_if

// *** sram_hold_buffer.sv ***
// small fifo holding pending write descriptors until their data arrives
`timescale 1ns/10ps
module sram_hold_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = late_write_sram_pkg::HOLD_DEPTH
) (
  input logic       clk,
  input logic       reset,
  hold_link_if.store link
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  slot [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0]   count;
  logic          doPush;
  logic          doPop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign link.outValid = (count != '0);
  assign link.full     = (count == (PW + 1)'(DEPTH));
  // a pop in the same cycle frees the slot for the push
  assign link.inReady  = !link.full || link.outReady;
  assign link.outData  = slot[rdPtr];
  assign doPush        = link.inValid && link.inReady;
  assign doPop         = link.outValid && link.outReady;

  always_ff @(posedge clk) begin
    if (doPush) begin
      slot[wrPtr] <= link.inData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= bump(wrPtr);
      end
      if (doPop) begin
        rdPtr <= bump(rdPtr);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (doPush && !doPop) begin
      count <= count + 1'b1;
    end else if (doPop && !doPush) begin
      count <= count - 1'b1;
    end
  end

endmodule : sram_hold_buffer

// *** late_write_sram_cmd_ctrl.sv ***
// command decode, burst counter and data pipeline of the late-write sram
`timescale 1ns/10ps
module late_write_sram_cmd_ctrl #(
  parameter int AW = late_write_sram_pkg::ADDR_W,
  parameter int NB = late_write_sram_pkg::LANES,
  parameter int LW = late_write_sram_pkg::LANE_W
) (
  input  logic             clk,
  input  logic             reset,
  input  logic             primary_select_n,
  input  logic             bank_sel_a,
  input  logic             bank_sel_b,
  input  logic             bank_pol_a,
  input  logic             bank_pol_b,
  input  logic             load_or_step,
  input  logic             write_sel_n,
  input  logic [AW-1:0]    addrIn,
  input  logic [NB-1:0]    lane_strobe_n,
  input  logic [NB*LW-1:0] dqIn,
  output logic [NB*LW-1:0] dqOut,
  output logic             dqOe,
  output logic             echo_clk_out,
  output logic             echoOe
);

  localparam int DW     = NB * LW;
  localparam int BW     = late_write_sram_pkg::BURST_W;
  localparam int DESC_W = AW + NB + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // straps and command decode

  logic                      polStageA;
  logic                      polStageB;
  logic                      polA;
  logic                      polB;
  logic                      bankMatch;
  logic                      isLoad;
  logic                      cmdTake;
  late_write_sram_pkg::op_t  op;
  late_write_sram_pkg::op_t  next_op;

  hold_link_if #(.W(DESC_W)) hold ();

  // static strap pins: two stages before use, running through reset
  always_ff @(posedge clk) begin
    polStageA <= bank_pol_a;
    polStageB <= bank_pol_b;
    polA      <= polStageA;
    polB      <= polStageB;
  end

  assign bankMatch = (bank_sel_a == polA) && (bank_sel_b == polB);
  assign isLoad    = !load_or_step;
  assign cmdTake   = hold.inReady;

  always_comb begin
    next_op = op;
    if (isLoad) begin
      if (!bankMatch) begin
        next_op = late_write_sram_pkg::OP_BANK_DES;
      end else if (primary_select_n) begin
        next_op = late_write_sram_pkg::OP_CHIP_DES;
      end else if (write_sel_n) begin
        next_op = late_write_sram_pkg::OP_READ;
      end else begin
        next_op = late_write_sram_pkg::OP_WRITE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op <= late_write_sram_pkg::OP_BANK_DES;
    end else if (cmdTake) begin
      op <= next_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // burst address counter

  logic [AW-1:0] baseAddr;
  logic [BW-1:0] burstCnt;
  logic [AW-1:0] accAddr;
  logic          inBurst;
  logic          stepBurst;

  function automatic logic [AW-1:0] burstAddr(input logic [AW-1:0] base,
                                              input logic [BW-1:0] cnt);
    logic [BW-1:0] low;
    low = base[BW-1:0] + cnt;
    return {base[AW-1:BW], low};
  endfunction : burstAddr

  assign inBurst   = (op == late_write_sram_pkg::OP_READ) ||
                     (op == late_write_sram_pkg::OP_WRITE);
  assign stepBurst = cmdTake && !isLoad && inBurst;
  assign accAddr   = isLoad ? addrIn
                            : burstAddr(baseAddr, burstCnt + late_write_sram_pkg::BURST_STEP);

  always_ff @(posedge clk) begin
    if (reset) begin
      baseAddr <= '0;
      burstCnt <= late_write_sram_pkg::BURST_START;
    end else if (cmdTake && isLoad && bankMatch && !primary_select_n) begin
      baseAddr <= addrIn;
      burstCnt <= late_write_sram_pkg::BURST_START;
    end else if (stepBurst) begin
      // wraps to the base after the fourth step
      burstCnt <= burstCnt + late_write_sram_pkg::BURST_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // storage and read pipeline

  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] rdAddr;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdAddr <= '0;
    end else if (cmdTake && next_op == late_write_sram_pkg::OP_READ) begin
      rdAddr <= accAddr;
    end
  end

  // outputs follow the operation taken one edge earlier
  always_ff @(posedge clk) begin
    if (reset) begin
      dqOe   <= 1'b0;
      echoOe <= 1'b0;
      dqOut  <= '0;
    end else begin
      dqOe   <= (op == late_write_sram_pkg::OP_READ);
      echoOe <= (op != late_write_sram_pkg::OP_BANK_DES);
      if (op == late_write_sram_pkg::OP_READ) begin
        dqOut <= mem[rdAddr];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      echo_clk_out <= 1'b0;
    end else begin
      echo_clk_out <= !echo_clk_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write pipeline: one descriptor per edge, drained two edges later

  logic          wantStore;
  logic          storeEn;
  logic [AW-1:0] storeAddr;
  logic [NB-1:0] storeStrb;

  assign wantStore     = (next_op == late_write_sram_pkg::OP_WRITE) && !(&lane_strobe_n);
  assign hold.inValid  = 1'b1;
  assign hold.inData   = {wantStore, lane_strobe_n, accAddr};
  assign hold.outReady = hold.full;
  assign storeEn       = hold.outValid && hold.outReady && hold.outData[DESC_W-1];
  assign storeAddr     = hold.outData[AW-1:0];
  assign storeStrb     = hold.outData[AW+NB-1:AW];

  sram_hold_buffer #(
    .W     (DESC_W),
    .DEPTH (late_write_sram_pkg::HOLD_DEPTH)
  ) sram_hold_buffer_inst (
    .clk   (clk),
    .reset (reset),
    .link  (hold.store)
  );

  always_ff @(posedge clk) begin
    if (storeEn) begin
      for (int i = 0; i < NB; i++) begin
        if (!storeStrb[i]) begin
          mem[storeAddr][i*LW +: LW] <= dqIn[i*LW +: LW];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic loadSel;
  logic readLoad;
  logic writeLoad;
  logic bankDes;
  logic chipDes;

  assign loadSel   = cmdTake && isLoad && bankMatch && !primary_select_n;
  assign readLoad  = loadSel && write_sel_n;
  assign writeLoad = loadSel && !write_sel_n;
  assign bankDes   = cmdTake && isLoad && !bankMatch;
  assign chipDes   = cmdTake && isLoad && bankMatch && primary_select_n;

  AST_BANK_DECODE: assert property (@(posedge clk) disable iff (reset)
    bankDes |=> op == late_write_sram_pkg::OP_BANK_DES)
    else $error("mismatched enables did not give bank deselect");

  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (reset)
    readLoad |-> ##2 (dqOe && echoOe))
    else $error("read data not driven one clock after command");

  AST_READ_ADDR: assert property (@(posedge clk) disable iff (reset)
    readLoad |=> rdAddr == $past(addrIn))
    else $error("read load did not latch the address");

  AST_WRITE_FLOAT: assert property (@(posedge clk) disable iff (reset)
    writeLoad |-> ##2 !dqOe)
    else $error("data pins driven after write command");

  AST_CHIP_FLOAT: assert property (@(posedge clk) disable iff (reset)
    chipDes |-> ##2 (!dqOe && echoOe))
    else $error("chip deselect floated echo or drove data");

  AST_BANK_FLOAT: assert property (@(posedge clk) disable iff (reset)
    bankDes |-> ##2 (!dqOe && !echoOe))
    else $error("bank deselect left pins driven");

  AST_HOLD_DESEL: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && !isLoad && op == late_write_sram_pkg::OP_BANK_DES)
      |-> ##2 (!dqOe && !echoOe))
    else $error("continue after bank deselect drove pins");

  AST_PREV_OUTPUT: assert property (@(posedge clk) disable iff (reset)
    cmdTake |=> dqOe == ($past(op) == late_write_sram_pkg::OP_READ))
    else $error("pins did not follow the previous operation");

  AST_BURST_STEP: assert property (@(posedge clk) disable iff (reset)
    stepBurst |=> burstCnt == $past(burstCnt) + late_write_sram_pkg::BURST_STEP)
    else $error("burst counter did not step by one");

  AST_WRAP: assert property (@(posedge clk) disable iff (reset)
    (stepBurst && op == late_write_sram_pkg::OP_READ
      && burstCnt == late_write_sram_pkg::BURST_LAST) |=> rdAddr == baseAddr)
    else $error("fourth continue did not wrap to base");

  AST_STORE: assert property (@(posedge clk) disable iff (reset)
    (writeLoad && !(&lane_strobe_n))
      |-> ##2 (storeEn && storeAddr == $past(addrIn, 2)))
    else $error("write not stored at its address two clocks later");

  AST_ABORT: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && next_op == late_write_sram_pkg::OP_WRITE && (&lane_strobe_n))
      |-> ##2 !storeEn)
    else $error("write abort stored data");

  AST_ECHO_TOGGLE: assert property (@(posedge clk) disable iff (reset)
    1'h1 |=> echo_clk_out != $past(echo_clk_out))
    else $error("echo clock stopped toggling");

  // continue cycles repeat the operation in flight
  AST_CHIP_CONT: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && !isLoad && op == late_write_sram_pkg::OP_CHIP_DES)
      |-> ##2 (!dqOe && echoOe))
    else $error("continue after chip deselect changed the pins");

  AST_WRITE_CONT: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && !isLoad && op == late_write_sram_pkg::OP_WRITE && !(&lane_strobe_n))
      |-> ##2 storeEn)
    else $error("write continue with enabled lanes stored nothing");

  AST_WRITE_CONT_FLOAT: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && !isLoad && op == late_write_sram_pkg::OP_WRITE)
      |-> ##2 !dqOe)
    else $error("data pins driven after write continue");

  AST_BASE_HOLD: assert property (@(posedge clk) disable iff (reset)
    stepBurst |=> baseAddr == $past(baseAddr))
    else $error("burst step changed the base address");

  AST_DESEL_STILL: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && !isLoad && !inBurst)
      |=> burstCnt == $past(burstCnt))
    else $error("continue after deselect moved the burst counter");

  // loads and echo enable
  AST_LOAD_RESTART: assert property (@(posedge clk) disable iff (reset)
    loadSel |=> burstCnt == late_write_sram_pkg::BURST_START)
    else $error("load did not restart the burst counter");

  AST_ECHO_KEEP: assert property (@(posedge clk) disable iff (reset)
    (cmdTake && next_op != late_write_sram_pkg::OP_BANK_DES)
      |-> ##2 echoOe)
    else $error("echo floated without a bank deselect");

  ////////////////////////////////////////////////////////////////////////////////
  // scenario covers

  COV_READ_BURST: cover property (@(posedge clk) disable iff (reset)
    readLoad ##1 stepBurst [*4]);
  COV_WRITE_STORE: cover property (@(posedge clk) disable iff (reset)
    writeLoad ##2 storeEn);
  COV_CHIP_DES: cover property (@(posedge clk) disable iff (reset)
    chipDes ##1 (cmdTake && !isLoad));
  COV_BANK_DES: cover property (@(posedge clk) disable iff (reset)
    readLoad ##1 bankDes);
  COV_WRITE_BURST: cover property (@(posedge clk) disable iff (reset)
    writeLoad ##1 stepBurst [*3]);

endmodule : late_write_sram_cmd_ctrl

// *** host_write_feeder.sv ***
// host-side model that presents write data two edges after each write command
`timescale 1ns/10ps
module host_write_feeder #(
  parameter int W = 36
) (
  input  logic         clk,
  input  logic         sendValid,
  input  logic [W-1:0] sendData,
  output logic [W-1:0] dqIn
);
  logic         pendValid = 1'b0;
  logic [W-1:0] pendData  = '0;

  initial dqIn = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one edge to capture, next edge drives; released bus shows inverted data
  always @(posedge clk) begin
    pendValid <= sendValid;
    pendData  <= sendData;
    dqIn      <= pendValid ? pendData : ~dqIn;
  end
endmodule : host_write_feeder

// *** late_write_sram_cmd_ctrl_tb_top.sv ***
// self-checking testbench for the late-write sram command controller
`timescale 1ns/10ps
module late_write_sram_cmd_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        primary_select_n = 1'b1;
  logic        bank_sel_a = 1'b1;
  logic        bank_sel_b = 1'b0;
  logic        bank_pol_a = 1'b1;
  logic        bank_pol_b = 1'b0;
  logic        load_or_step = 1'b1;
  logic        write_sel_n = 1'b1;
  logic [3:0]  addrIn = 4'h0;
  logic [3:0]  lane_strobe_n = 4'hf;
  logic [35:0] dqIn;
  logic [35:0] dqOut;
  logic        dqOe;
  logic        echo_clk_out;
  logic        echoOe;
  logic        sendValid = 1'b0;
  logic [35:0] sendData = '0;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  late_write_sram_cmd_ctrl late_write_sram_cmd_ctrl_inst (
    .clk(clk), .reset(reset), .primary_select_n(primary_select_n),
    .bank_sel_a(bank_sel_a), .bank_sel_b(bank_sel_b), .bank_pol_a(bank_pol_a),
    .bank_pol_b(bank_pol_b), .load_or_step(load_or_step), .write_sel_n(write_sel_n),
    .addrIn(addrIn), .lane_strobe_n(lane_strobe_n), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .echo_clk_out(echo_clk_out), .echoOe(echoOe));

  host_write_feeder host_write_feeder_inst (
    .clk(clk), .sendValid(sendValid), .sendData(sendData), .dqIn(dqIn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bm low forces a bank mismatch; wn low also hands data to the host model
  task automatic step(input logic ls, wn, csn, bm, input logic [3:0] a, s,
                      input logic [35:0] d);
    @(posedge clk);
    load_or_step     <= ls;
    write_sel_n      <= wn;
    primary_select_n <= csn;
    bank_sel_a       <= bm ? bank_pol_a : ~bank_pol_a;
    bank_sel_b       <= bank_pol_b;
    addrIn           <= a;
    lane_strobe_n    <= s;
    sendValid        <= ~wn;
    sendData         <= d;
    #1;
  endtask : step

  task automatic chk_pins(input logic eDq, eEcho);
    chk("dqOe", {35'h0, eDq}, {35'h0, dqOe});
    chk("echoOe", {35'h0, eEcho}, {35'h0, echoOe});
  endtask : chk_pins

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_burst();
    logic [35:0] e [5] = '{36'h111111111, 36'h222222222, 36'h333333333,
                           36'h444444444, 36'h111111111};
    logic        ec;
    step(0, 0, 0, 1, 4'h5, 4'h0, e[0]);
    step(1, 0, 0, 1, 4'h0, 4'h0, e[1]);
    step(1, 0, 0, 1, 4'h0, 4'h0, e[2]);
    step(1, 0, 0, 1, 4'h0, 4'h0, e[3]);
    chk_pins(0, 1);
    step(0, 1, 0, 1, 4'h5, 4'hf, '0);
    step(1, 1, 0, 1, 4'h0, 4'hf, '0);
    for (int i = 0; i < 5; i++) begin
      if (i < 3)
        step(1, 1, 0, 1, 4'h0, 4'hf, '0);
      else
        step(0, 1, 1, 1, 4'h0, 4'hf, '0);
      chk("dqOut", e[i], dqOut);
      chk_pins(1, 1);
    end
    step(1, 1, 1, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 1);
    ec = echo_clk_out;
    step(1, 1, 1, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 1);
    chk("echo_clk_out", {35'h0, ~ec}, {35'h0, echo_clk_out});
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 1);
  endtask : t_burst

  task automatic t_strobes();
    step(0, 0, 0, 1, 4'h9, 4'h0, 36'h123456789);
    step(0, 0, 0, 1, 4'h9, 4'ha, 36'hfedcba987);
    step(0, 0, 0, 1, 4'ha, 4'h0, 36'h0aa55aa55);
    step(0, 0, 0, 1, 4'ha, 4'hf, 36'h9ffffffff);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    step(0, 1, 0, 1, 4'h9, 4'hf, '0);
    step(0, 1, 0, 1, 4'ha, 4'hf, '0);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk("dqOut", 36'h125c96787, dqOut);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk("dqOut", 36'h0aa55aa55, dqOut);
  endtask : t_strobes

  task automatic t_bank();
    step(0, 1, 0, 1, 4'h5, 4'hf, '0);
    step(0, 1, 0, 0, 4'h5, 4'hf, '0);
    step(1, 1, 0, 1, 4'h0, 4'hf, '0);
    chk_pins(1, 1);
    step(1, 1, 0, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 0);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 0);
  endtask : t_bank

  task automatic t_polarity();
    @(posedge clk);
    bank_pol_a <= 1'b0;
    bank_pol_b <= 1'b1;
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    step(0, 1, 0, 1, 4'h5, 4'hf, '0);
    step(0, 1, 0, 0, 4'h5, 4'hf, '0);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk("dqOut", 36'h111111111, dqOut);
    chk_pins(1, 1);
    step(0, 1, 1, 1, 4'h0, 4'hf, '0);
    chk_pins(0, 0);
  endtask : t_polarity

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_burst();
    t_strobes();
    t_bank();
    t_polarity();
    tally_and_finish();
  end
endmodule : late_write_sram_cmd_ctrl_tb_top
